// file: design/twl_params.svh
// Constants for the two-wire link interface block.
// Assumes inclusion by bare name from the top module and the bench.
`ifndef TWL_PARAMS_SVH
`define TWL_PARAMS_SVH
`define TWL_CLK_HZ 20000000
`define TWL_BIT_HZ 1000000
`define TWL_CTS_BITS 32
`define TWL_CTS_HOLD 6'h3F
`define TWL_RS_CR1 2'h0
`define TWL_RS_CR2_3 2'h1
`define TWL_RS_TX_CONT 2'h2
`define TWL_RS_TX_TERM 2'h3
`define TWL_CH_TX 1'h0
`define TWL_CH_RX 1'h1
`define TWL_DMA_CYC_STROBE 2'h2
`define TWL_ADDR_RESET 16'h0000
`define TWL_CNT_RESET 16'h0000
`endif

// file: design/twl_pkg.sv
// Types shared by the two-wire link interface.
// Assumes twl_params.svh is on the include path.
package twl_pkg;
  typedef enum logic [1:0] {
    TWL_IDLE = 2'h0,
    TWL_REQ = 2'h1,
    TWL_CYC1 = 2'h3,
    TWL_CYC2 = 2'h2
  } twl_dma_st_t;

  typedef enum logic [2:0] {
    TWL_W_CR1 = 3'h0,
    TWL_W_CR2 = 3'h1,
    TWL_W_CR3 = 3'h2,
    TWL_W_TXC = 3'h3,
    TWL_W_TXT = 3'h4,
    TWL_W_CR4 = 3'h5,
    TWL_W_NONE = 3'h7
  } twl_wsel_t;

  typedef enum logic [1:0] {
    TWL_R_SR1 = 2'h0,
    TWL_R_SR2 = 2'h1,
    TWL_R_RXF = 2'h2,
    TWL_R_NONE = 2'h3
  } twl_rsel_t;

  // Select toward the link controller
  typedef struct packed {
    logic cs;
    logic rs_high;
    logic rs_low;
    logic rd;
  } twl_sel_t;

  typedef struct packed {
    twl_dma_st_t st;
    logic ch;
    logic [15:0] addr;
    logic [15:0] cnt0;
    logic [15:0] cnt1;
    logic [15:0] adr0;
    logic [15:0] adr1;
    logic blk_end;
    logic [15:0] div;
    logic bit_en;
    logic rx_prev;
    logic [15:0] rx_cnt;
    logic half_a;
    logic got_half;
    logic last_pol;
    logic synced;
    logic rx_data;
    logic [5:0] cts_cnt;
    logic cts;
    logic line_tx;
    logic line_en;
  } twl_state_t;
endpackage

// file: design/twl_top.sv
// Two-wire link interface: DMA sequencer, link controller select mux and
// a frequency-shift modem with clear-to-send delay.
// Assumes one 20 MHz clock; processor bus inputs are synchronous to it.
//
// Overview of operation
// R01 - Processor mode supervises, DMA mode moves bytes
// R02 - DMA selected by chip select, five address bits; setup decodes only addr_low_i[2:0]
// R03 - Service request raises DMA request, strobe cycle 2
// R04 - DMA drives address, direction, acknowledge, block end
// R05 - Halt steal; channel 0 transmit, 1 receive
// R06 - Link interrupt comes from link controller only
// R07 - Carrier detect held active; two outputs unused
// R08 - Processor mode: select by A1-0 and read/write
// R09 - DMA cycle 2: select high, low from block end
// R10 - Select 00 control 1; 01 control 2/3
// R11 - Select 10 continue; 11 terminate or control 4
// R12 - Reads: status 1, status 2, receive FIFO
// R13 - Line driven only while request-to-send active
// R14 - Strobe from received signal gives recovered clock
// R15 - No retransmission of received data
// R16 - Request-to-send output is inverted input
// R17 - Clear-to-send after 32 recovered bit periods
// R18 - During delay send frequency of transmit data
// R19 - Block end at transmit end drops clear-to-send
// R20 - Accept bit on valid halves, alternating polarity
// R21 - Receive output high when invalid or unsynced
// R22 - Processor halts and grants via bus available
// R23 - Delay count restarts when request drops
`include "twl_params.svh"
module twl_top import twl_pkg::*; #(
  parameter int CLK_HZ = `TWL_CLK_HZ,
  parameter int BIT_HZ = `TWL_BIT_HZ,
  parameter int CTS_BITS = `TWL_CTS_BITS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Processor bus
  input wire logic dma_cs_i,
  input wire logic link_cs_i,
  input wire logic [4:0] addr_low_i,
  input wire logic rw_i,
  input wire logic proc_wr_i,
  input wire logic [15:0] cfg_data_i,
  // Halt request and grant
  output logic dma_req_o,
  input wire logic dma_grant_i,
  // Link controller side
  input wire logic rx_service_request_i,
  input wire logic tx_service_request_i,
  input wire logic link_irq_i,
  input wire logic link_rts_i,
  input wire logic link_txd_i,
  input wire logic terminal_ready_loop_out_i,
  input wire logic flag_detect_out_i,
  output logic link_irq_o,
  output logic carrier_detect_o,
  output logic transfer_strobe_o,
  output logic channel_ack_a_o,
  output logic block_end_o,
  output logic [15:0] mem_addr_o,
  output logic mem_rw_o,
  output twl_sel_t link_sel_o,
  output twl_wsel_t link_wsel_o,
  output twl_rsel_t link_rsel_o,
  output logic buf_to_dma_o,
  // Modem toward link controller
  output logic recovered_bit_clock_o,
  output logic rx_data_o,
  output logic cts_o,
  output logic rts_out_b_o,
  // Two-wire line
  input wire logic line_receive_in_i,
  output logic shifted_line_signal_o,
  output logic line_drive_en_o
);
  localparam int HALF_DIV = CLK_HZ / (2 * BIT_HZ);
  localparam logic [15:0] HALF_C = 16'(HALF_DIV - 1);
  localparam logic [15:0] Q_C = 16'(HALF_DIV / 2);
  localparam logic [5:0] CTS_C = 6'(CTS_BITS - 1);

  initial begin
    if (HALF_DIV < 2 || HALF_DIV > 65535 || CTS_BITS < 1 || CTS_BITS > 63)
      $error("twl_top: unsupported clock ratio or delay");
  end

  twl_state_t s_r;
  twl_state_t s_nxt;
  logic in_dma;
  logic last_byte;
  logic [1:0] rs;
  logic rd;

  // ************************************************************
  // Register select mux
  // ************************************************************
  assign in_dma = (s_r.st == TWL_CYC2);
  assign last_byte = s_r.ch ? (s_r.cnt1 == 16'h0001)
                            : (s_r.cnt0 == 16'h0001);

  always_comb begin
    if (in_dma) begin
      rs = {1'b1, s_r.blk_end}; // R09
      rd = s_r.ch; // R09
    end else begin
      rs = addr_low_i[1:0]; // R08
      rd = rw_i; // R08
    end
  end

  always_comb begin
    link_sel_o.cs = link_cs_i | in_dma; // R09
    link_sel_o.rs_high = rs[1];
    link_sel_o.rs_low = rs[0];
    link_sel_o.rd = rd;
    link_wsel_o = TWL_W_NONE;
    link_rsel_o = TWL_R_NONE;
    if (link_sel_o.cs && !rd) begin
      case (rs)
        `TWL_RS_CR1: link_wsel_o = TWL_W_CR1; // R10
        `TWL_RS_CR2_3: link_wsel_o = cfg_data_i[0] ? TWL_W_CR3
                                                 : TWL_W_CR2; // R10
        `TWL_RS_TX_CONT: link_wsel_o = TWL_W_TXC; // R11
        `TWL_RS_TX_TERM: link_wsel_o = cfg_data_i[1] ? TWL_W_CR4
                                                   : TWL_W_TXT; // R11
        default: link_wsel_o = TWL_W_NONE;
      endcase
    end else if (link_sel_o.cs) begin
      if (rs[1])
        link_rsel_o = TWL_R_RXF; // R12
      else if (rs[0])
        link_rsel_o = TWL_R_SR2; // R12
      else
        link_rsel_o = TWL_R_SR1; // R12
    end
  end

  // Address-control bit stands in cfg_data_i[0] for select 01 and cfg_data_i[1] for select 11 in the mux above
  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.bit_en = 1'b0;
    // Processor-mode setup of channel address and count
    if (dma_cs_i && proc_wr_i && s_r.st == TWL_IDLE) begin // R02
      case (addr_low_i[2:0])
        3'h0: s_nxt.adr0 = cfg_data_i;
        3'h1: s_nxt.cnt0 = cfg_data_i;
        3'h2: s_nxt.adr1 = cfg_data_i;
        3'h3: s_nxt.cnt1 = cfg_data_i;
        default: s_nxt.adr0 = s_r.adr0;
      endcase
    end
    // Halt-steal sequence, transmit has priority
    case (s_r.st)
      TWL_IDLE: begin
        if (tx_service_request_i && s_r.cnt0 != `TWL_CNT_RESET) begin // R03
          s_nxt.st = TWL_REQ;
          s_nxt.ch = `TWL_CH_TX; // R05
        end else if (rx_service_request_i &&
                     s_r.cnt1 != `TWL_CNT_RESET) begin
          s_nxt.st = TWL_REQ;
          s_nxt.ch = `TWL_CH_RX; // R05
        end
      end
      TWL_REQ: begin
        if (dma_grant_i) begin // R22
          s_nxt.st = TWL_CYC1;
          s_nxt.addr = s_r.ch ? s_r.adr1 : s_r.adr0; // R04
          s_nxt.blk_end = last_byte; // R04
        end
      end
      TWL_CYC1: s_nxt.st = TWL_CYC2;
      TWL_CYC2: begin
        s_nxt.st = TWL_IDLE;
        s_nxt.blk_end = 1'b0;
        if (s_r.ch) begin
          s_nxt.adr1 = s_r.adr1 + 16'h0001;
          s_nxt.cnt1 = s_r.cnt1 - 16'h0001;
        end else begin
          s_nxt.adr0 = s_r.adr0 + 16'h0001;
          s_nxt.cnt0 = s_r.cnt0 - 16'h0001;
        end
      end
      default: s_nxt.st = TWL_IDLE;
    endcase

    // Bit strobe recovered from line edges
    s_nxt.rx_prev = line_receive_in_i;
    if (s_r.rx_prev != line_receive_in_i) begin
      s_nxt.rx_cnt = Q_C; // R14
    end else if (s_r.rx_cnt == HALF_C) begin
      s_nxt.rx_cnt = 16'h0000;
    end else begin
      s_nxt.rx_cnt = s_r.rx_cnt + 16'h0001;
    end
    if (s_r.rx_cnt == HALF_C) begin
      if (!s_r.got_half) begin
        s_nxt.half_a = line_receive_in_i;
        s_nxt.got_half = 1'b1;
      end else begin
        s_nxt.got_half = 1'b0;
        s_nxt.bit_en = 1'b1; // R14
        // Any half pair is legal; polarity must alternate bit to bit
        if (s_r.half_a != s_r.last_pol) begin // R20
          s_nxt.synced = 1'b1;
          s_nxt.rx_data = (s_r.half_a == line_receive_in_i);
        end else begin
          s_nxt.synced = 1'b0;
        end
        s_nxt.last_pol = line_receive_in_i;
      end
    end
    if (!s_nxt.synced)
      s_nxt.rx_data = 1'b1; // R21

    // Transmit frequency: toggle every half bit for zero, hold the level
    // for one; received data is never looped back
    if (s_r.div == HALF_C) begin
      s_nxt.div = 16'h0000;
      if (!link_txd_i || !s_r.line_en)
        s_nxt.line_tx = ~s_r.line_tx; // R18 R15
    end else begin
      s_nxt.div = s_r.div + 16'h0001;
    end
    s_nxt.line_en = link_rts_i; // R13

    // Clear-to-send delay
    if (!link_rts_i) begin
      s_nxt.cts_cnt = 6'h00; // R23
      s_nxt.cts = 1'b0;
    end else if (in_dma && s_r.blk_end && !s_r.ch) begin
      // Parked count keeps clear-to-send off until request drops
      s_nxt.cts = 1'b0; // R19
      s_nxt.cts_cnt = `TWL_CTS_HOLD; // R19
    end else if (s_r.bit_en && !s_r.cts &&
                 s_r.cts_cnt != `TWL_CTS_HOLD) begin
      if (s_r.cts_cnt == CTS_C)
        s_nxt.cts = 1'b1; // R17
      else
        s_nxt.cts_cnt = s_r.cts_cnt + 6'h01;
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_r <= '0;
      s_r.st <= TWL_IDLE;
      s_r.addr <= `TWL_ADDR_RESET;
      s_r.rx_data <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign dma_req_o = (s_r.st == TWL_REQ); // R03
  assign transfer_strobe_o = in_dma; // R03 R01
  assign buf_to_dma_o = !in_dma && dma_cs_i; // R02
  assign channel_ack_a_o = s_r.ch; // R04
  assign block_end_o = in_dma && s_r.blk_end; // R04
  assign mem_addr_o = s_r.addr; // R04
  assign mem_rw_o = ~s_r.ch; // R04
  assign link_irq_o = link_irq_i; // R06
  assign carrier_detect_o = 1'b1; // R07
  assign recovered_bit_clock_o = s_r.got_half; // R14
  assign rx_data_o = s_r.rx_data;
  assign cts_o = s_r.cts;
  assign rts_out_b_o = ~link_rts_i; // R16
  assign shifted_line_signal_o = s_r.line_en & s_r.line_tx; // R13
  assign line_drive_en_o = s_r.line_en; // R13
endmodule

// file: tb/twl_chk_sva.sv
// Port checker for the two-wire link interface top.
// Assumes binding onto twl_top; one clock, async active-low reset.
module twl_chk_sva import twl_pkg::*; (
  // Watched ports
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic link_cs_i,
  input wire logic dma_cs_i,
  input wire logic buf_to_dma_o,
  input wire logic shifted_line_signal_o,
  input wire logic [4:0] addr_low_i,
  input wire logic rw_i,
  input wire logic dma_req_o,
  input wire logic dma_grant_i,
  input wire logic link_irq_i,
  input wire logic link_irq_o,
  input wire logic link_rts_i,
  input wire logic carrier_detect_o,
  input wire logic transfer_strobe_o,
  input wire logic channel_ack_a_o,
  input wire logic block_end_o,
  input wire twl_sel_t link_sel_o,
  input wire logic cts_o,
  input wire logic rts_out_b_o,
  input wire logic line_drive_en_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Properties
  // ****
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_rts; rts_out_b_o == !link_rts_i; endproperty
  a_rts: assert property (p_rts) else $error("rts out");
  property p_cd; carrier_detect_o; endproperty
  a_cd: assert property (p_cd) else $error("carrier");
  property p_irq; link_irq_o == link_irq_i; endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_drv; line_drive_en_o |-> $past(link_rts_i); endproperty
  a_drv: assert property (p_drv) else $error("line drive");
  property p_gnt; dma_req_o && dma_grant_i |-> ##2 transfer_strobe_o;
  endproperty
  a_gnt: assert property (p_gnt) else $error("strobe");
  property p_dsel; transfer_strobe_o |-> link_sel_o.cs && link_sel_o.rs_high
    && link_sel_o.rs_low == block_end_o && link_sel_o.rd == channel_ack_a_o;
  endproperty
  a_dsel: assert property (p_dsel) else $error("dma select");
  property p_psel; link_cs_i && !transfer_strobe_o |-> link_sel_o.cs &&
    link_sel_o.rs_high == addr_low_i[1] && link_sel_o.rs_low == addr_low_i[0]
    && link_sel_o.rd == rw_i;
  endproperty
  a_psel: assert property (p_psel) else $error("proc select");
  property p_ctsr; !link_rts_i [*2] |-> !cts_o; endproperty
  a_ctsr: assert property (p_ctsr) else $error("cts held");
  property p_buf; dma_cs_i && !transfer_strobe_o |-> buf_to_dma_o;
  endproperty
  a_buf: assert property (p_buf) else $error("dma buffer");
  property p_fsq; !line_drive_en_o |-> !shifted_line_signal_o; endproperty
  a_fsq: assert property (p_fsq) else $error("line quiet");
endmodule
bind twl_top twl_chk_sva u_chk (.*);

// file: tb/twl_remote.sv
// Remote modem model: sends random bits on the receive line.
// Assumes HALF clocks per half-bit; line toggles while released.
module twl_remote #(parameter int HALF = 10) (
  // Control and line
  input wire logic clk_i,
  input wire logic en_i,
  output logic line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  logic first, d;
  initial line_o = 1'h0;
  always @(posedge clk_i) begin
    if (!en_i) begin
      // Released: no stale level for the receiver to latch
      line_o <= ~line_o;
      n <= 0;
    end else begin
      n <= (n == 2 * HALF - 1) ? 0 : n + 1;
      if (n == 0) begin
        first = ~line_o;
        d = 1'($urandom());
        line_o <= first;
      end else if (n == HALF) begin
        line_o <= d ? first : ~first;
      end
    end
  end
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the two-wire link interface top.
// Assumes design, package and checker compiled first.
`include "twl_params.svh"
module tb_top import twl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_b_i, dma_cs_i, link_cs_i, rw_i, proc_wr_i, dma_grant_i;
  logic [4:0] addr_low_i;
  logic [15:0] cfg_data_i, mem_addr_o;
  logic rx_service_request_i, tx_service_request_i, link_irq_i, link_rts_i;
  logic link_txd_i, terminal_ready_loop_out_i, flag_detect_out_i, dma_req_o;
  logic link_irq_o, carrier_detect_o, transfer_strobe_o, channel_ack_a_o;
  logic block_end_o, mem_rw_o, buf_to_dma_o, recovered_bit_clock_o;
  logic cts_o, rts_out_b_o, line_receive_in_i, shifted_line_signal_o;
  logic line_drive_en_o, rem_en, rx_data_o;
  logic [1:0] v, rs;
  twl_sel_t link_sel_o;
  twl_wsel_t link_wsel_o;
  twl_rsel_t link_rsel_o;
  int mismatches = 0;
  int n_checks = 0;
  int k;
  logic ok;
  localparam int BIT_CLKS = `TWL_CLK_HZ / `TWL_BIT_HZ;
  twl_top u_dut (.*);
  twl_remote u_rem (.clk_i(clk_i), .en_i(rem_en), .line_o(line_receive_in_i));
  // ****
  // Clock, grant and tasks
  // ****
  initial begin
    clk_i = 1'h0;
    forever #25 clk_i = ~clk_i;
  end
  // Processor halts and grants one cycle after the request
  always @(posedge clk_i) dma_grant_i <= dma_req_o;
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (s !== 1'h1 && k < lim);
  endtask
  function automatic twl_wsel_t exp_w(input logic [1:0] r, input logic [1:0] c);
    case (r)
      2'h0: return TWL_W_CR1;
      2'h1: return c[0] ? TWL_W_CR3 : TWL_W_CR2;
      2'h2: return TWL_W_TXC;
      default: return c[1] ? TWL_W_CR4 : TWL_W_TXT;
    endcase
  endfunction
  task automatic prog(input logic [2:0] r, input logic [15:0] d);
    @(posedge clk_i);
    {dma_cs_i, proc_wr_i, rw_i} <= 3'h6;
    addr_low_i <= {2'h0, r};
    cfg_data_i <= d;
    @(posedge clk_i);
    {dma_cs_i, proc_wr_i} <= 2'h0;
  endtask
  task automatic dma(input logic ch, input logic [15:0] a, input int n);
    prog(ch ? 3'h2 : 3'h0, a);
    prog(ch ? 3'h3 : 3'h1, 16'(n));
    if (ch) rx_service_request_i <= 1'h1;
    else tx_service_request_i <= 1'h1;
    for (int i = 0; i < n; i++) begin
      wait_hi(transfer_strobe_o, 99);
      chk(16'(transfer_strobe_o), 16'h1);
      chk(16'(channel_ack_a_o), 16'(ch));
      chk(16'(mem_rw_o), 16'(!ch));
      chk(16'(block_end_o), 16'(i == n - 1));
      if (i == 0) chk(mem_addr_o, a);
    end
    @(posedge clk_i);
    {rx_service_request_i, tx_service_request_i} <= 2'h0;
    $display("dma channel %0d done", ch);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ****
  // Tests
  // ****
  initial begin
    {dma_cs_i, link_cs_i, rw_i, proc_wr_i, rem_en} = '0;
    {addr_low_i, cfg_data_i, rx_service_request_i, tx_service_request_i} = '0;
    {link_irq_i, link_rts_i, link_txd_i, rst_b_i} = '0;
    {terminal_ready_loop_out_i, flag_detect_out_i} = '0;
    void'($urandom(95418));
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'h1;
    for (int i = 0; i < 24; i++) begin
      v = 2'($urandom());
      rs = 2'($urandom());
      @(posedge clk_i);
      {link_cs_i, rw_i, proc_wr_i} <= 3'h5;
      addr_low_i <= 5'h0;
      cfg_data_i <= {14'h0, v};
      link_irq_i <= 1'($urandom());
      @(negedge clk_i);
      chk(16'(link_wsel_o), 16'(TWL_W_CR1));
      @(posedge clk_i);
      rw_i <= i[0];
      proc_wr_i <= !i[0];
      addr_low_i <= {3'h0, rs};
      @(negedge clk_i);
      if (i[0]) chk(16'(link_rsel_o), rs[1] ? 16'(TWL_R_RXF) : 16'(rs));
      else chk(16'(link_wsel_o), 16'(exp_w(rs, v)));
    end
    @(posedge clk_i);
    {link_cs_i, proc_wr_i} <= 2'h0;
    $display("select test done");
    chk(16'(rx_data_o), 16'h1);
    rem_en <= 1'h1;
    link_rts_i <= 1'h1;
    link_txd_i <= 1'($urandom());
    wait_hi(cts_o, 3000);
    // First recovered period is partial, so allow one bit of slack
    ok = k >= (`TWL_CTS_BITS - 1) * BIT_CLKS;
    ok = ok && k <= (`TWL_CTS_BITS + 2) * BIT_CLKS;
    chk(16'(ok), 16'h1);
    chk(16'(line_drive_en_o), 16'h1);
    dma(1'h0, 16'($urandom()), 1 + $urandom() % 3);
    repeat (2) @(negedge clk_i);
    chk(16'(cts_o), 16'h0);
    dma(1'h1, 16'($urandom()), 2);
    repeat (40) @(negedge clk_i);
    chk(16'(cts_o), 16'h0);
    @(posedge clk_i);
    link_rts_i <= 1'h0;
    repeat (3) @(negedge clk_i);
    chk(16'(line_drive_en_o), 16'h0);
    @(posedge clk_i);
    link_rts_i <= 1'h1;
    repeat (600) @(negedge clk_i);
    chk(16'(cts_o), 16'h0);
    $display("modem test done");
    print_verdict();
  end
  initial begin
    #1000000;
    mismatches++;
    print_verdict();
  end
endmodule
